// ==== rtl/cnrc_node.sv ====
// congestion notify node: message generation, ingress translation, edge reaction
// assumes inputs synchronous to clk_sys and downstream framing of entries by stream
//
// What this block does
// - Normal now and Normal before: no congestion message leaves the node.
// - Any state change launches the matching transition message.
// - While congested, a sustained message repeats every update period.
// - Back in Normal, periodic messages stop at once.
// - Received dlcis are translated to outgoing dlcis, tagged per packet stream.
// - Edge marks congested access channels busy and may block all new calls.
// - Congested or a channel busy: prioritise, drop discardable frames and low speech blocks; else full.
// - With forwarding on, received messages pass on untranslated instead.
// - Node holds exactly three states: Normal, Moderate, Maximum.
// - Update period is at least ten seconds.
// - Cause codes are fixed eight-bit values per transition.
`timescale 1ns/1ps
`default_nettype none

module cnrc_node #(
    parameter int unsigned CONG_PERIOD_CYC = cnrc_pkg::TCONG_CYC
) (
    // clock and reset
    input  wire logic                           clk_sys,
    input  wire logic                           resetn,
    // own congestion measure
    input  wire logic [1:0]                     congLevel,
    // generated congestion message
    output logic                                msgValid,
    output logic      [cnrc_pkg::CAUSE_W-1:0]   msgCause,
    input  wire logic                           msgReady,
    // received message entries, one dlci each
    input  wire logic                           rxValid,
    input  wire logic [cnrc_pkg::DLCI_W-1:0]    rxDlci,
    input  wire logic [cnrc_pkg::CAUSE_W-1:0]   rxCause,
    input  wire logic                           rxLast,
    output logic                                rxReady,
    // outgoing entries, backward or forwarded
    output logic                                outValid,
    output logic      [cnrc_pkg::DLCI_W-1:0]    outDlci,
    output logic      [cnrc_pkg::STREAM_W-1:0]  outStream,
    output logic      [cnrc_pkg::CAUSE_W-1:0]   outCause,
    output logic                                outLast,
    output logic                                outFwd,
    input  wire logic                           outReady,
    // options
    input  wire logic                           forwardEn,
    input  wire logic                           blockAllEn,
    input  wire logic                           discardEn,
    input  wire logic                           lsbDropEn,
    // translation table load
    input  wire logic                           cfgWe,
    input  wire logic [cnrc_pkg::MAP_IDX_W-1:0] cfgIdx,
    input  wire logic [cnrc_pkg::DLCI_W-1:0]    cfgOutDlci,
    input  wire logic [cnrc_pkg::STREAM_W-1:0]  cfgStream,
    // edge and traffic treatment
    output logic      [cnrc_pkg::NUM_STREAMS-1:0] chanBusy,
    output logic                                blockNewCalls,
    output logic                                dropDiscardable,
    output logic                                dropLsbBlocks,
    output logic                                prioritySplit
);

    // level 3 on the pins is read as maximum, never as a fourth state
    function automatic cnrc_pkg::cnrc_state_type level_to_state(input logic [1:0] lvl);
        if (lvl == cnrc_pkg::LEVEL_NORMAL)
            return cnrc_pkg::ST_NORMAL;
        else if (lvl == cnrc_pkg::LEVEL_MODERATE)
            return cnrc_pkg::ST_MODERATE;
        else
            return cnrc_pkg::ST_MAXIMUM;
    endfunction

    // cause code for a change from one state to another
    function automatic logic [cnrc_pkg::CAUSE_W-1:0] transition_cause(
        input cnrc_pkg::cnrc_state_type prev,
        input cnrc_pkg::cnrc_state_type cur
    );
        logic [cnrc_pkg::CAUSE_W-1:0] c;
        c = cnrc_pkg::CAUSE_SUSTAINED;
        case (cur)
            cnrc_pkg::ST_MODERATE: begin
                c = (prev == cnrc_pkg::ST_MAXIMUM) ? cnrc_pkg::CAUSE_ABATING
                                                   : cnrc_pkg::CAUSE_INCREASING;
            end
            cnrc_pkg::ST_MAXIMUM: begin
                c = cnrc_pkg::CAUSE_CRITICAL;
            end
            cnrc_pkg::ST_NORMAL: begin
                c = (prev == cnrc_pkg::ST_MAXIMUM) ? cnrc_pkg::CAUSE_CRIT_CLEAR
                                                   : cnrc_pkg::CAUSE_CLEARING;
            end
            default: begin
                c = cnrc_pkg::CAUSE_SUSTAINED;
            end
        endcase
        return c;
    endfunction

    cnrc_pkg::cnrc_state_type       stateQ;
    cnrc_pkg::cnrc_state_type       prevQ;
    logic [cnrc_pkg::PERIOD_CNT_W-1:0] periodCnt;
    logic [cnrc_pkg::DLCI_W-1:0]    mapDlci;
    logic [cnrc_pkg::STREAM_W-1:0]  mapStream;
    logic [cnrc_pkg::NUM_STREAMS-1:0] next_chanBusy;

    // message launch decode
    wire logic stateChange = (stateQ != prevQ);
    wire logic congested   = (stateQ != cnrc_pkg::ST_NORMAL);
    wire logic periodTick  = congested && !stateChange &&
                             (periodCnt == cnrc_pkg::PERIOD_CNT_W'(CONG_PERIOD_CYC - 1));
    wire logic msgLaunch   = stateChange || periodTick;
    wire logic [cnrc_pkg::CAUSE_W-1:0] launchCause =
        stateChange ? transition_cause(prevQ, stateQ) : cnrc_pkg::CAUSE_SUSTAINED;

    // received entry decode
    wire logic rxAccept    = rxValid && rxReady;
    wire logic causeSets   = (rxCause == cnrc_pkg::CAUSE_INCREASING) ||
                             (rxCause == cnrc_pkg::CAUSE_SUSTAINED)  ||
                             (rxCause == cnrc_pkg::CAUSE_CRITICAL)   ||
                             (rxCause == cnrc_pkg::CAUSE_ABATING);
    wire logic causeClears = (rxCause == cnrc_pkg::CAUSE_CLEARING) ||
                             (rxCause == cnrc_pkg::CAUSE_CRIT_CLEAR);
    wire logic terminate   = rxAccept && !forwardEn;
    wire logic degraded    = congested || (|chanBusy);

    // one entry held at a time; a stalled consumer stalls the sender
    assign rxReady = !outValid || outReady;

    cnrc_dlci_map u_map (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .cfgWe      (cfgWe),
        .cfgIdx     (cfgIdx),
        .cfgOutDlci (cfgOutDlci),
        .cfgStream  (cfgStream),
        .rdIdx      (rxDlci[cnrc_pkg::MAP_IDX_W-1:0]),
        .rdDlci     (mapDlci),
        .rdStream   (mapStream)
    );

    // state tracking, current and one cycle back
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            stateQ <= cnrc_pkg::ST_NORMAL;
            prevQ  <= cnrc_pkg::ST_NORMAL;
        end else begin
            stateQ <= level_to_state(congLevel);
            prevQ  <= stateQ;
        end
    end

    // update period timer, restarts on each transition
    always_ff @(posedge clk_sys) begin
        if (!resetn || !congested || stateChange || periodTick)
            periodCnt <= cnrc_pkg::RST_CNT;
        else
            periodCnt <= periodCnt + 1'b1;
    end

    // message holder; a newer launch replaces an unsent one
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            msgValid <= 1'b0;
            msgCause <= cnrc_pkg::RST_CAUSE;
        end else if (msgLaunch) begin
            msgValid <= 1'b1;
            msgCause <= launchCause;
        end else if (msgReady) begin
            msgValid <= 1'b0;
        end
    end

    // outgoing entry: translated backward or passed on as received
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            outValid  <= 1'b0;
            outDlci   <= cnrc_pkg::RST_DLCI;
            outStream <= cnrc_pkg::RST_STREAM;
            outCause  <= cnrc_pkg::RST_CAUSE;
            outLast   <= 1'b0;
            outFwd    <= 1'b0;
        end else if (rxAccept) begin
            outValid  <= 1'b1;
            outDlci   <= forwardEn ? rxDlci : mapDlci;
            outStream <= mapStream;
            outCause  <= rxCause;
            outLast   <= rxLast;
            outFwd    <= forwardEn;
        end else if (outReady) begin
            outValid  <= 1'b0;
        end
    end

    // trunk conditioning per access channel
    always_comb begin
        next_chanBusy = chanBusy;
        if (terminate && causeSets)
            next_chanBusy[mapStream] = 1'b1;
        else if (terminate && causeClears)
            next_chanBusy[mapStream] = 1'b0;
    end

    // drop and priority flags follow own state and busy channels, call blocking busy channels only; all registered
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            chanBusy        <= cnrc_pkg::RST_BUSY;
            blockNewCalls   <= 1'b0;
            dropDiscardable <= 1'b0;
            dropLsbBlocks   <= 1'b0;
            prioritySplit   <= 1'b0;
        end else begin
            chanBusy        <= next_chanBusy;
            blockNewCalls   <= blockAllEn && (|next_chanBusy);
            dropDiscardable <= degraded && discardEn;
            dropLsbBlocks   <= degraded && lsbDropEn;
            prioritySplit   <= degraded;
        end
    end

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    property p_quiet_normal;
        (stateQ == cnrc_pkg::ST_NORMAL && prevQ == cnrc_pkg::ST_NORMAL) |-> !msgLaunch;
    endproperty
    a_quiet_normal: assert property (p_quiet_normal) else $error("message in normal");

    property p_increasing;
        (prevQ == cnrc_pkg::ST_NORMAL && stateQ == cnrc_pkg::ST_MODERATE)
            |=> msgValid && msgCause == 8'h02;
    endproperty
    a_increasing: assert property (p_increasing) else $error("no increasing msg");

    property p_crit_clear;
        (prevQ == cnrc_pkg::ST_MAXIMUM && stateQ == cnrc_pkg::ST_NORMAL)
            |=> msgValid && msgCause == 8'h07;
    endproperty
    a_crit_clear: assert property (p_crit_clear) else $error("bad clear cause");

    property p_sustained;
        periodTick |=> msgValid && msgCause == 8'h04 && periodCnt == 0;
    endproperty
    a_sustained: assert property (p_sustained) else $error("no sustained msg");

    property p_timer_stops;
        (stateQ == cnrc_pkg::ST_NORMAL && prevQ == cnrc_pkg::ST_NORMAL) |-> periodCnt == 0;
    endproperty
    a_timer_stops: assert property (p_timer_stops) else $error("timer runs in normal");

    property p_period_bound;
        periodTick |-> $past(periodCnt) == cnrc_pkg::PERIOD_CNT_W'(CONG_PERIOD_CYC - 2);
    endproperty
    a_period_bound: assert property (p_period_bound) else $error("period count wrong");

    property p_translate;
        (rxAccept && !forwardEn) |=> outValid && !outFwd && outDlci == $past(mapDlci)
            && outStream == $past(mapStream);
    endproperty
    a_translate: assert property (p_translate) else $error("bad translation");

    property p_busy;
        (terminate && rxCause == 8'h06) |=> chanBusy[$past(mapStream)];
    endproperty
    a_busy: assert property (p_busy) else $error("channel not busy");

    property p_full_service;
        (stateQ == cnrc_pkg::ST_NORMAL && chanBusy == 0 && !terminate)
            |=> !dropDiscardable && !dropLsbBlocks && !prioritySplit;
    endproperty
    a_full_service: assert property (p_full_service) else $error("service degraded");

    property p_forward;
        (rxAccept && forwardEn) |=> outFwd && outDlci == $past(rxDlci) && outCause == $past(rxCause);
    endproperty
    a_forward: assert property (p_forward) else $error("forward altered entry");

    property p_three_states;
        stateQ inside {cnrc_pkg::ST_NORMAL, cnrc_pkg::ST_MODERATE, cnrc_pkg::ST_MAXIMUM};
    endproperty
    a_three_states: assert property (p_three_states) else $error("illegal state");

    c_critical:  cover property (prevQ == cnrc_pkg::ST_MODERATE && stateQ == cnrc_pkg::ST_MAXIMUM);
    c_periodic:  cover property (periodTick);
    c_forward:   cover property (rxAccept && forwardEn);
    c_blockAll:  cover property (blockNewCalls);

endmodule // cnrc_node

`default_nettype wire

// ==== pkg/cnrc_pkg.sv ====
// constants, codes and types shared by the congestion notify node
// assumes a single 20 MHz system clock and a synchronous active-low reset
`default_nettype none

package cnrc_pkg;

    // clock rate and update period
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned TCONG_MIN_S   = 10;                    // seconds, least period
    localparam int unsigned TCONG_CYC     = TCONG_MIN_S * CLK_HZ;  // cycles per period
    localparam int unsigned PERIOD_CNT_W  = 32;

    // widths of message fields
    localparam int unsigned DLCI_W        = 13;
    localparam int unsigned CAUSE_W       = 8;
    localparam int unsigned STREAM_W      = 2;
    localparam int unsigned NUM_STREAMS   = 4;
    localparam int unsigned MAP_IDX_W     = 4;
    localparam int unsigned MAP_DEPTH     = 16;

    // cause codes carried in a message
    localparam logic [CAUSE_W-1:0] CAUSE_INCREASING = 8'h02;
    localparam logic [CAUSE_W-1:0] CAUSE_CLEARING   = 8'h03;
    localparam logic [CAUSE_W-1:0] CAUSE_SUSTAINED  = 8'h04;
    localparam logic [CAUSE_W-1:0] CAUSE_CRITICAL   = 8'h06;
    localparam logic [CAUSE_W-1:0] CAUSE_CRIT_CLEAR = 8'h07;
    localparam logic [CAUSE_W-1:0] CAUSE_ABATING    = 8'h08;

    // measured congestion level on the input pins
    localparam logic [1:0] LEVEL_NORMAL   = 2'h0;
    localparam logic [1:0] LEVEL_MODERATE = 2'h1;

    // values after reset
    localparam logic [DLCI_W-1:0]       RST_DLCI   = 13'h0000;
    localparam logic [STREAM_W-1:0]     RST_STREAM = 2'h0;
    localparam logic [CAUSE_W-1:0]      RST_CAUSE  = 8'h00;
    localparam logic [NUM_STREAMS-1:0]  RST_BUSY   = 4'h0;
    localparam logic [PERIOD_CNT_W-1:0] RST_CNT    = 32'h0000_0000;

    // node congestion state, one-hot
    typedef enum logic [2:0] {
        ST_NORMAL   = 3'b001,
        ST_MODERATE = 3'b010,
        ST_MAXIMUM  = 3'b100
    } cnrc_state_type;

endpackage

`default_nettype wire

// ==== rtl/cnrc_dlci_map.sv ====
// dlci translation table: incoming index to outgoing dlci and packet stream
// assumes software-side loading through the plain write port, one entry a cycle
`default_nettype none
`timescale 1ns/1ps

module cnrc_dlci_map (
    // clock and reset
    input  wire logic                           clk_sys,
    input  wire logic                           resetn,
    // table load
    input  wire logic                           cfgWe,
    input  wire logic [cnrc_pkg::MAP_IDX_W-1:0] cfgIdx,
    input  wire logic [cnrc_pkg::DLCI_W-1:0]    cfgOutDlci,
    input  wire logic [cnrc_pkg::STREAM_W-1:0]  cfgStream,
    // lookup
    input  wire logic [cnrc_pkg::MAP_IDX_W-1:0] rdIdx,
    output logic      [cnrc_pkg::DLCI_W-1:0]    rdDlci,
    output logic      [cnrc_pkg::STREAM_W-1:0]  rdStream
);

    logic [cnrc_pkg::DLCI_W-1:0]   dlciMem   [cnrc_pkg::MAP_DEPTH];
    logic [cnrc_pkg::STREAM_W-1:0] streamMem [cnrc_pkg::MAP_DEPTH];

    // entries clear at reset so an unloaded index maps to stream 0
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            for (int i = 0; i < cnrc_pkg::MAP_DEPTH; i++) begin
                dlciMem[i]   <= cnrc_pkg::RST_DLCI;
                streamMem[i] <= cnrc_pkg::RST_STREAM;
            end
        end else if (cfgWe) begin
            dlciMem[cfgIdx]   <= cfgOutDlci;
            streamMem[cfgIdx] <= cfgStream;
        end
    end

    // read is a plain mux so the lookup lands in the same cycle
    assign rdDlci   = dlciMem[rdIdx];
    assign rdStream = streamMem[rdIdx];

endmodule // cnrc_dlci_map

`default_nettype wire

// ==== sim/cnrc_far_model.sv ====
// far-side consumer of the node's generated messages and outgoing entries
// assumes the node samples both ready lines on the rising edge of clk_sys
`timescale 1ns/1ps
`default_nettype none

module cnrc_far_model (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic resetn,
    // pacing, high holds both consumers off
    input  wire logic stall,
    // ready towards the node
    output var  logic msgReady,
    output var  logic outReady,
    // end user view of generated messages
    input  wire logic       msgValid,
    input  wire logic [7:0] msgCause,
    input  wire logic       implicitInd,
    output var  logic [1:0] loadStep,
    output var  logic [1:0] explCnt
);
    // end user of type B traffic; load step 3 original, 2 committed, 1 three quarters, 0 half
    // a notification is an ordinary event, never an error; types A, D, E would hold load
    wire logic       take        = msgValid && msgReady;
    wire logic       explicitMsg = take && (msgCause inside {cnrc_pkg::CAUSE_INCREASING,
                                   cnrc_pkg::CAUSE_SUSTAINED, cnrc_pkg::CAUSE_CRITICAL,
                                   cnrc_pkg::CAUSE_ABATING});
    wire logic       clearMsg    = take && (msgCause inside {cnrc_pkg::CAUSE_CLEARING,
                                   cnrc_pkg::CAUSE_CRIT_CLEAR});
    wire logic [1:0] explTarget  = (explCnt >= 2'h2) ? 2'h0 : 2'h2 - explCnt;

    // rate based steps, never below half the committed rate
    always @(posedge clk_sys) begin
        if (!resetn) begin
            loadStep <= 2'h3;
            explCnt  <= 2'h0;
        end else if (implicitInd) begin
            loadStep <= (explCnt != 2'h0) ? 2'h0 : ((loadStep == 2'h3) ? 2'h2 : loadStep);
        end else if (explicitMsg) begin
            explCnt <= (explCnt == 2'h3) ? 2'h3 : explCnt + 2'h1;
            if (loadStep > explTarget) loadStep <= explTarget;
        end else if (clearMsg) begin
            loadStep <= (loadStep == 2'h3) ? 2'h3 : loadStep + 2'h1;
            if (loadStep == 2'h2) explCnt <= 2'h0;
        end
    end
    // known level before the first edge
    initial begin
        msgReady = 1'b0;
        outReady = 1'b0;
    end

    // ready moves just after an edge, never in mid-cycle
    always @(posedge clk_sys) begin
        msgReady <= resetn & ~stall;
        outReady <= resetn & ~stall;
    end
endmodule // cnrc_far_model

`default_nettype wire

// ==== sim/cnrc_node_tb_top.sv ====
// self-checking bench for the congestion notify node
// assumes the far-side consumer model and a short update period parameter
`timescale 1ns/1ps
`default_nettype none

module cnrc_node_tb_top;
    localparam int unsigned PERIOD = 20; // short update period keeps the run brief

    logic        clk_sys, resetn, stall, msgValid, msgReady, rxValid, rxLast, rxReady;
    logic [1:0]  congLevel, cfgStream, outStream;
    logic [7:0]  msgCause, rxCause, outCause;
    logic [12:0] rxDlci, outDlci, cfgOutDlci;
    logic [3:0]  cfgIdx, chanBusy;
    logic        outValid, outLast, outFwd, outReady, forwardEn, blockAllEn, discardEn;
    logic        lsbDropEn, cfgWe, blockNewCalls, dropDiscardable, dropLsbBlocks, prioritySplit;
    logic        implicitInd;
    logic [1:0]  loadStep, explCnt;
    int          error_cnt, comparisons, cycleCnt;

    cnrc_node #(.CONG_PERIOD_CYC(PERIOD)) uut (
        .clk_sys(clk_sys), .resetn(resetn), .congLevel(congLevel),
        .msgValid(msgValid), .msgCause(msgCause), .msgReady(msgReady),
        .rxValid(rxValid), .rxDlci(rxDlci), .rxCause(rxCause), .rxLast(rxLast),
        .rxReady(rxReady), .outValid(outValid), .outDlci(outDlci), .outStream(outStream),
        .outCause(outCause), .outLast(outLast), .outFwd(outFwd), .outReady(outReady),
        .forwardEn(forwardEn), .blockAllEn(blockAllEn), .discardEn(discardEn),
        .lsbDropEn(lsbDropEn), .cfgWe(cfgWe), .cfgIdx(cfgIdx), .cfgOutDlci(cfgOutDlci),
        .cfgStream(cfgStream), .chanBusy(chanBusy), .blockNewCalls(blockNewCalls),
        .dropDiscardable(dropDiscardable), .dropLsbBlocks(dropLsbBlocks),
        .prioritySplit(prioritySplit));

    cnrc_far_model far (.clk_sys(clk_sys), .resetn(resetn), .stall(stall),
        .msgReady(msgReady), .outReady(outReady), .msgValid(msgValid), .msgCause(msgCause),
        .implicitInd(implicitInd), .loadStep(loadStep), .explCnt(explCnt));

    // clock and hang guard; the whole run needs well under a thousand cycles
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycleCnt++;
        if (cycleCnt == 5000) begin
            error_cnt++;
            end_sim();
        end
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (exp !== got) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_cnt(input string name, input int exp, input int got);
        comparisons++;
        if (exp != got) begin
            error_cnt++;
            $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // counts cycles with msgValid high over n cycles, none expected
    task automatic quiet(input int n);
        int hits;
        hits = 0;
        repeat (n) begin
            @(negedge clk_sys);
            if (msgValid !== 1'b0) hits++;
        end
        chk_cnt("quiet msgValid", 0, hits);
    endtask

    // moves the measured level and waits a bounded time for the message
    task automatic step_lvl(input logic [1:0] lvl, input logic [7:0] cause);
        int i;
        congLevel = lvl;
        for (i = 0; i < 6 && msgValid !== 1'b1; i++) @(negedge clk_sys);
        chk("msgValid", 16'(1), 16'(msgValid));
        chk("msgCause", 16'(cause), 16'(msgCause));
        @(negedge clk_sys);
    endtask

    task automatic wr(input logic [3:0] idx, input logic [12:0] dlci, input logic [1:0] strm);
        cfgWe = 1'b1;
        cfgIdx = idx;
        cfgOutDlci = dlci;
        cfgStream = strm;
        @(negedge clk_sys);
        cfgWe = 1'b0;
        @(negedge clk_sys); // strobe stays low over one edge before the next write
    endtask

    // offers one entry, optionally checks hold-off first, then judges the out entry
    task automatic send(input logic [12:0] dlci, input logic [7:0] cause, input logic last,
                        input logic [12:0] expDlci, input logic [1:0] expStrm, input int hold);
        int i;
        bit ok;
        rxValid = 1'b1;
        rxDlci = dlci;
        rxCause = cause;
        rxLast = last;
        for (i = 0; i < hold; i++) begin
            chk("rxReady held off", 16'(0), 16'(rxReady));
            chk("outValid stands", 16'(1), 16'(outValid));
            @(negedge clk_sys);
        end
        if (hold > 0) stall = 1'b0;
        ok = 1'b0;
        for (i = 0; i < 8 && !ok; i++) begin
            ok = (rxReady === 1'b1);
            @(negedge clk_sys);
        end
        rxValid = 1'b0;
        for (i = 0; i < 4 && outValid !== 1'b1; i++) @(negedge clk_sys);
        chk("outValid", 16'(1), 16'(outValid));
        chk("outDlci", 16'(expDlci), 16'(outDlci));
        if (!forwardEn) chk("outStream", 16'(expStrm), 16'(outStream));
        chk("outCause", 16'(cause), 16'(outCause));
        chk("outLast", 16'(last), 16'(outLast));
        chk("outFwd", 16'(forwardEn), 16'(outFwd));
        @(negedge clk_sys);
    endtask

    task automatic t_levels;
        logic [1:0] lv [6];
        logic [7:0] cs [6];
        lv = '{2'h1, 2'h2, 2'h1, 2'h0, 2'h3, 2'h0};
        cs = '{cnrc_pkg::CAUSE_INCREASING, cnrc_pkg::CAUSE_CRITICAL, cnrc_pkg::CAUSE_ABATING,
               cnrc_pkg::CAUSE_CLEARING, cnrc_pkg::CAUSE_CRITICAL, cnrc_pkg::CAUSE_CRIT_CLEAR};
        for (int k = 0; k < 6; k++) step_lvl(lv[k], cs[k]);
    endtask

    task automatic t_period;
        int n;
        step_lvl(2'h1, cnrc_pkg::CAUSE_INCREASING);
        n = 1;
        while (msgValid !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        chk_cnt("sustained gap", PERIOD, n);
        chk("sustained cause", 16'(cnrc_pkg::CAUSE_SUSTAINED), 16'(msgCause));
        chk("prioritySplit own", 16'(1), 16'(prioritySplit));
        @(negedge clk_sys);
        step_lvl(2'h0, cnrc_pkg::CAUSE_CLEARING);
        quiet(3 * PERIOD);
    endtask

    task automatic t_rx;
        wr(4'h5, 13'h0abc, 2'h2);
        wr(4'h9, 13'h1234, 2'h1);
        send(13'h0005, cnrc_pkg::CAUSE_CRITICAL, 1'b0, 13'h0abc, 2'h2, 0);
        send(13'h0009, cnrc_pkg::CAUSE_INCREASING, 1'b1, 13'h1234, 2'h1, 0);
        repeat (2) @(negedge clk_sys);
        chk("chanBusy set", 16'(4'h6), 16'(chanBusy));
        chk("blockNewCalls", 16'(1), 16'(blockNewCalls));
        chk("prioritySplit", 16'(1), 16'(prioritySplit));
        chk("dropDiscardable", 16'(1), 16'(dropDiscardable));
        chk("dropLsbBlocks off", 16'(0), 16'(dropLsbBlocks));
        discardEn = 1'b0;
        lsbDropEn = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("dropLsbBlocks on", 16'(1), 16'(dropLsbBlocks));
        chk("dropDiscardable off", 16'(0), 16'(dropDiscardable));
        // upper dlci bits ignored by the table; second offer meets a stalled consumer
        stall = 1'b1;
        send(13'h0015, cnrc_pkg::CAUSE_SUSTAINED, 1'b0, 13'h0abc, 2'h2, 0);
        send(13'h0009, cnrc_pkg::CAUSE_SUSTAINED, 1'b1, 13'h1234, 2'h1, 4);
        send(13'h0005, cnrc_pkg::CAUSE_CLEARING, 1'b0, 13'h0abc, 2'h2, 0);
        repeat (2) @(negedge clk_sys);
        chk("chanBusy partial", 16'(4'h2), 16'(chanBusy));
        send(13'h0009, cnrc_pkg::CAUSE_CRIT_CLEAR, 1'b1, 13'h1234, 2'h1, 0);
        repeat (3) @(negedge clk_sys);
        chk("chanBusy clear", 16'(4'h0), 16'(chanBusy));
        chk("blockNewCalls clear", 16'(0), 16'(blockNewCalls));
        chk("prioritySplit clear", 16'(0), 16'(prioritySplit));
        chk("dropLsbBlocks clear", 16'(0), 16'(dropLsbBlocks));
        // forwarded entries pass untranslated and leave the busy marks alone
        forwardEn = 1'b1;
        send(13'h0005, cnrc_pkg::CAUSE_CRITICAL, 1'b1, 13'h0005, 2'h0, 0);
        repeat (2) @(negedge clk_sys);
        chk("chanBusy fwd", 16'(4'h0), 16'(chanBusy));
        forwardEn = 1'b0;
    endtask

    // main sequence: inputs known at time zero, reset for eight cycles
    initial begin
        error_cnt = 0;
        comparisons = 0;
        cycleCnt = 0;
        {resetn, stall, congLevel, rxValid, rxDlci, rxCause, rxLast, cfgWe} = '0;
        {cfgIdx, cfgOutDlci, cfgStream, forwardEn, lsbDropEn} = '0;
        implicitInd = 1'b0;
        blockAllEn = 1'b1;
        discardEn = 1'b1;
        repeat (8) @(negedge clk_sys);
        chk("msgValid reset", 16'(0), 16'(msgValid));
        chk("outValid reset", 16'(0), 16'(outValid));
        chk("rxReady reset", 16'(1), 16'(rxReady));
        chk("chanBusy reset", 16'(cnrc_pkg::RST_BUSY), 16'(chanBusy));
        resetn = 1'b1;
        quiet(30);
        t_levels();
        chk("loadStep after levels", 16'(2'h1), 16'(loadStep));
        chk("explCnt saturates", 16'(2'h3), 16'(explCnt));
        t_period();
        chk("loadStep after period", 16'(2'h1), 16'(loadStep));
        implicitInd = 1'b1;
        @(negedge clk_sys);
        implicitInd = 1'b0;
        chk("loadStep implicit", 16'(2'h0), 16'(loadStep));
        t_rx();
        end_sim();
    end
endmodule // cnrc_node_tb_top

`default_nettype wire
